// [hdl/rx_port_and_gpio_control_regs.sv]
/*
  Receiver port, I/O voltage and general-purpose pin register bank.
  Assumes a byte-wide register port from an I2C target, synchronous to sys_clk,
  and receiver status flags already synchronous.
*/
// Operation
// - Link-ok output source by bits 5:4
// - Sync output source by bits 3:2
// - Select fields written only by local controller
// - Both receiver ports run independently
// - Bit 1 enables port 1, reset on
// - Bit 0 enables port 0, reset on
// - Override bit picks written or detected voltage
// - Reads return detected level without override
// - Pin levels readable at bits 6:0
// - Source 100, select 000 drives value bit
// - Source bits 4:2, select bits 7:5
`include "rx_hub_regs_defs.svh"

module rx_port_and_gpio_control_regs #(
  parameter int PIN_COUNT = 7
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register access
  input wire rx_hub_regs_pkg::reg_req_s req,
  output logic [7:0] rdata,
  // Receiver status per port
  input wire rx_hub_regs_pkg::rx_status_s port0_status,
  input wire rx_hub_regs_pkg::rx_status_s port1_status,
  // Status outputs
  output logic link_ok_out,
  output logic sync_out,
  // Receiver enables
  output logic first_receiver_enable,
  output logic second_receiver_enable,
  // I/O supply
  input wire logic detected_3v3,
  output logic pin_voltage_select,
  output logic [1:0] supply_mode,
  // General-purpose pins
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_input_enable,
  output logic pin0_out,
  output logic pin0_oe
);

  logic [1:0] link_sel_r; // Link-ok source
  logic [1:0] sync_sel_r; // Sync source
  logic [1:0] port_en_r; // Receiver enables
  logic volt_sel_r; // Written voltage select
  logic volt_ovr_r; // Override
  logic [1:0] mode_r; // Written supply mode
  logic [3:0] iov_rsvd_r; // Reserved read-write nibble
  logic [PIN_COUNT-1:0] in_en_r; // Input enables
  logic [7:0] p0_ctrl_r; // Pin 0 control byte
  logic [PIN_COUNT-1:0] level_r; // Sampled pin levels
  logic det_sel; // Detected voltage as select bit
  logic [1:0] det_mode; // Detected voltage as mode
  // Per-register write strobes
  logic wr_rpc, wr_iov, wr_inen, wr_p0; // High for one cycle with the write

  // Address decode for a write at a given offset
  function automatic logic hit(input rx_hub_regs_pkg::reg_req_s r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  // Pin level byte has no strobe, so writes to it simply drop
  assign wr_rpc = hit(req, `OFS_RX_PORT_CTRL);
  assign wr_iov = hit(req, `OFS_IO_VOLT_CTRL);
  assign wr_inen = hit(req, `OFS_PIN_IN_EN);
  assign wr_p0 = hit(req, `OFS_PIN0_OUT_CTRL);

  // Selects: remote writes leave them unchanged, so a far master cannot redirect status
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      link_sel_r <= 2'h0;
      sync_sel_r <= 2'h0;
    end else if (wr_rpc && !req.remote) begin
      link_sel_r <= req.wdata[`RPC_LINK_SEL_LSB +: 2];
      sync_sel_r <= req.wdata[`RPC_SYNC_SEL_LSB +: 2];
    end
  end

  // Port enables, reset to enabled; each bit is independent
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_en_r <= 2'h3;
    end else if (wr_rpc) begin
      port_en_r[1] <= req.wdata[`RPC_SECOND_RECEIVER_ENABLE_BIT];
      port_en_r[0] <= req.wdata[`RPC_FIRST_RECEIVER_ENABLE_BIT];
    end
  end

  // Enables go straight from the flops to the receivers
  assign first_receiver_enable = port_en_r[0];
  assign second_receiver_enable = port_en_r[1];

  // One combiner per status output; ports evaluated separately
  status_combiner link_comb (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .sel(rx_hub_regs_pkg::status_src_e'(link_sel_r)),
    .port_en(port_en_r),
    .flag({port1_status.link_ok, port0_status.link_ok}),
    .result(link_ok_out)
  );

  // Sync combiner mirrors the link-ok one, sharing the enables
  status_combiner sync_comb (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .sel(rx_hub_regs_pkg::status_src_e'(sync_sel_r)),
    .port_en(port_en_r),
    .flag({port1_status.sync_ok, port0_status.sync_ok}),
    .result(sync_out)
  );

  // Voltage control fields
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      volt_sel_r <= 1'b0;
      volt_ovr_r <= 1'b0;
      mode_r <= `IOV_MODE_1V8;
      iov_rsvd_r <= `IOV_RSVD_RESET;
    end else if (wr_iov) begin
      volt_sel_r <= req.wdata[`IOV_SEL_BIT];
      volt_ovr_r <= req.wdata[`IOV_OVR_BIT];
      mode_r <= req.wdata[`IOV_MODE_LSB +: 2];
      iov_rsvd_r <= req.wdata[3:0];
    end
  end

  // Detected level in both encodings
  assign det_sel = detected_3v3;
  assign det_mode = detected_3v3 ? `IOV_MODE_3V3 : `IOV_MODE_1V8;

  // Override chooses written values, else detected
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_voltage_select <= 1'b0;
      supply_mode <= `IOV_MODE_1V8;
    end else begin
      pin_voltage_select <= volt_ovr_r ? volt_sel_r : det_sel;
      supply_mode <= volt_ovr_r ? mode_r : det_mode;
    end
  end

  // Input enables, all on after reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      in_en_r <= `PIN_IN_EN_RESET;
    end else if (wr_inen) begin
      in_en_r <= req.wdata[PIN_COUNT-1:0];
    end
  end

  // Enables reach the pad input buffers; ordering against outputs is up to software
  assign pin_input_enable = in_en_r;

  // Pin levels masked by the input enable each cycle; a disabled pin reads zero
  // One flop per pin keeps the read path a plain register
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_level
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          level_r[g] <= 1'b0;
        end else begin
          level_r[g] <= pin_in[g] & in_en_r[g];
        end
      end
    end
  endgenerate

  // Pin 0 control byte
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      p0_ctrl_r <= `P0_RESET;
    end else if (wr_p0) begin
      p0_ctrl_r <= req.wdata;
    end
  end

  // Pin 0 drive; software keeps enable low while input enabled
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin0_out <= 1'b0;
      pin0_oe <= 1'b0;
    end else begin
      pin0_oe <= p0_ctrl_r[`P0_OE_BIT]; // Follows its bit, no interlock
      if (p0_ctrl_r[`P0_SRC_LSB +: 3] == `P0_SRC_REGVAL &&
          p0_ctrl_r[`P0_SEL_LSB +: 3] == `P0_SEL_REGVAL) begin
        pin0_out <= p0_ctrl_r[`P0_VAL_BIT];
      end else begin
        pin0_out <= 1'b0;
      end
    end
  end

  // Read data, registered one cycle after the read strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      // Port control reserved bits and detected voltage fields are formed here, not stored
      case (req.addr)
        `OFS_RX_PORT_CTRL: rdata <= {`RPC_RSVD_VAL, link_sel_r, sync_sel_r, port_en_r};
        `OFS_IO_VOLT_CTRL: rdata <= volt_ovr_r ? {volt_sel_r, 1'b1, mode_r, iov_rsvd_r}
                                               : {det_sel, 1'b0, det_mode, iov_rsvd_r};
        `OFS_PIN_LEVELS: rdata <= {1'b0, level_r};
        `OFS_PIN_IN_EN: rdata <= {1'b0, in_en_r};
        `OFS_PIN0_OUT_CTRL: rdata <= p0_ctrl_r;
        default: rdata <= 8'h00; // Unmapped reads as zero
      endcase
    end
  end

endmodule : rx_port_and_gpio_control_regs

// [hdl/rx_hub_regs_defs.svh]
/*
  Offsets, field positions, reset values for the receiver port and pin register bank.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef RX_HUB_REGS_DEFS_SVH
`define RX_HUB_REGS_DEFS_SVH

// Register offsets
`define OFS_RX_PORT_CTRL 8'h0C
`define OFS_IO_VOLT_CTRL 8'h0D
`define OFS_PIN_LEVELS 8'h0E
`define OFS_PIN_IN_EN 8'h0F
`define OFS_PIN0_OUT_CTRL 8'h10

// Receiver port control fields
`define RPC_SYNC_SEL_LSB 2
`define RPC_LINK_SEL_LSB 4
`define RPC_SECOND_RECEIVER_ENABLE_BIT 1
`define RPC_FIRST_RECEIVER_ENABLE_BIT 0
`define RPC_RSVD_VAL 2'h2
`define RPC_RESET 8'h83

// Voltage control fields
`define IOV_SEL_BIT 7
`define IOV_OVR_BIT 6
`define IOV_MODE_LSB 4
`define IOV_RSVD_RESET 4'h9
`define IOV_RESET 8'h09
`define IOV_MODE_1V8 2'h0
`define IOV_MODE_3V3 2'h3

// Input enables
`define PIN_IN_EN_RESET 7'h7F

// Pin 0 output control fields
`define P0_SEL_LSB 5
`define P0_SRC_LSB 2
`define P0_VAL_BIT 1
`define P0_OE_BIT 0
`define P0_SRC_REGVAL 3'h4
`define P0_SEL_REGVAL 3'h0
`define P0_RESET 8'h00

`endif

// [hdl/rx_hub_regs_pkg.sv]
/*
  Types shared by the register bank and its status combiner.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rx_hub_regs_pkg;

  // Status source choice for link-ok and sync outputs
  typedef enum logic [1:0] {
    src_port0,
    src_port1,
    src_any_enabled,
    src_all_enabled
  } status_src_e;

  // Per-port receiver status
  typedef struct packed {
    logic link_ok;
    logic sync_ok;
  } rx_status_s;

  // Register access request from the I2C target
  typedef struct packed {
    logic wr;
    logic rd;
    logic remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : rx_hub_regs_pkg

// [hdl/status_combiner.sv]
/*
  Combines two per-port flags into one status output by a 2-bit select.
  Assumes synchronous inputs on sys_clk; output is registered.
*/
module status_combiner (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Controls
  input wire rx_hub_regs_pkg::status_src_e sel,
  input wire logic [1:0] port_en,
  // Per-port flags
  input wire logic [1:0] flag,
  // Result
  output logic result
);

  logic result_nxt; // Combined flag
  logic [1:0] seen; // Flags of enabled ports only

  // Disabled ports count as absent in any and all
  always_comb begin
    seen = flag & port_en;
    case (sel)
      rx_hub_regs_pkg::src_port0: result_nxt = flag[0];
      rx_hub_regs_pkg::src_port1: result_nxt = flag[1];
      rx_hub_regs_pkg::src_any_enabled: result_nxt = |seen;
      rx_hub_regs_pkg::src_all_enabled: result_nxt = (|port_en) && (seen == port_en);
      default: result_nxt = 1'b0;
    endcase
  end

  // Registered output to keep the status pin glitch free
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      result <= 1'b0;
    end else begin
      result <= result_nxt;
    end
  end

endmodule : status_combiner

// [verif/rx_hub_regs_assertions.sv]
/* Port-level checks for the receiver port and pin register bank.
   Assumes single-cycle request strobes synchronous to sys_clk. */
module rx_hub_regs_assertions #(
  parameter int PIN_COUNT = 7
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register access
  input wire rx_hub_regs_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  // Receiver side
  input wire rx_hub_regs_pkg::rx_status_s port0_status,
  input wire rx_hub_regs_pkg::rx_status_s port1_status,
  input wire logic link_ok_out,
  input wire logic sync_out,
  input wire logic first_receiver_enable,
  input wire logic second_receiver_enable,
  // Supply and pins
  input wire logic detected_3v3,
  input wire logic pin_voltage_select,
  input wire logic [1:0] supply_mode,
  input wire logic [PIN_COUNT-1:0] pin_in,
  input wire logic [PIN_COUNT-1:0] pin_input_enable,
  input wire logic pin0_out,
  input wire logic pin0_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Port pairs, bit 1 is port 1
  wire [1:0] en = {second_receiver_enable, first_receiver_enable};
  wire [1:0] lk = {port1_status.link_ok, port0_status.link_ok};
  wire [1:0] sy = {port1_status.sync_ok, port0_status.sync_ok};
  // Disabled ports never count toward any or all
  function automatic logic pick(input logic [1:0] s, input logic [1:0] e, input logic [1:0] f);
    return s[1] ? (s[0] ? (e != 2'b00 && (f & e) == e) : |(f & e)) : f[s[0]];
  endfunction : pick
  // Local write to the port control byte
  sequence port_wr;
    req.wr && !req.remote && req.addr == 8'h0C;
  endsequence
  // Voltage byte write with a given override bit
  sequence volt_wr(bit ov);
    req.wr && req.addr == 8'h0D && req.wdata[6] == ov;
  endsequence
  a_status_source: assert property (
    port_wr |=> ##1 link_ok_out == pick($past(req.wdata[5:4], 2), $past(en), $past(lk))
      && sync_out == pick($past(req.wdata[3:2], 2), $past(en), $past(sy)))
    else $error("status source mismatch");
  a_port_enables: assert property (
    req.wr && req.addr == 8'h0C |=> en == $past(req.wdata[1:0]))
    else $error("receiver enable mismatch");
  a_pin0_drive: assert property (
    req.wr && req.addr == 8'h10 && req.wdata[0] |=> ##1 pin0_oe
      && pin0_out == ($past(req.wdata[7:1], 2) == 7'h09))
    else $error("pin 0 drive mismatch");
  a_volt_override: assert property (
    volt_wr(1'b1) |=> ##1 {pin_voltage_select, supply_mode}
      == {$past(req.wdata[7], 2), $past(req.wdata[5:4], 2)})
    else $error("override voltage mismatch");
  a_volt_detect: assert property (
    volt_wr(1'b0) ##1 $stable(detected_3v3) [*2]
      |-> {pin_voltage_select, supply_mode} == {3{detected_3v3}})
    else $error("detected voltage mismatch");
  a_unmapped_read: assert property (
    req.rd && !(req.addr inside {[8'h0C:8'h10]}) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_read: assert property (
    req.rd && req.addr == 8'h0C |=> rdata[7:6] == 2'b10)
    else $error("reserved bits wrong");
  a_input_enable: assert property (
    req.wr && req.addr == 8'h0F |=> pin_input_enable == $past(req.wdata[PIN_COUNT-1:0]))
    else $error("input enable mismatch");
endmodule : rx_hub_regs_assertions

bind rx_port_and_gpio_control_regs rx_hub_regs_assertions #(.PIN_COUNT(PIN_COUNT)) i_chk (
  .sys_clk(sys_clk), .resetn(resetn), .req(req), .rdata(rdata),
  .port0_status(port0_status), .port1_status(port1_status),
  .link_ok_out(link_ok_out), .sync_out(sync_out),
  .first_receiver_enable(first_receiver_enable),
  .second_receiver_enable(second_receiver_enable), .detected_3v3(detected_3v3),
  .pin_voltage_select(pin_voltage_select), .supply_mode(supply_mode), .pin_in(pin_in),
  .pin_input_enable(pin_input_enable), .pin0_out(pin0_out), .pin0_oe(pin0_oe));

// [verif/i2c_host_model.sv]
/* Controller model: issues single byte requests to the bank, local or remote.
   Assumes the bank takes a request on the edge where the strobe is high. */
module i2c_host_model (
  // Clock
  input wire logic sys_clk,
  // Request toward the bank
  output rx_hub_regs_pkg::reg_req_s req
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bus idle from time zero
  initial req = '0;
  // One byte, held for one edge; idle cycle after so strobes never merge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic rm);
    @(posedge sys_clk) #1;
    req <= '{wr: w, rd: !w, remote: rm, addr: a, wdata: d};
    @(posedge sys_clk) #1;
    req <= '0;
  endtask : xfer
endmodule : i2c_host_model

// [verif/test_rx_port_and_gpio_control_regs.sv]
/* Self-checking bench for the register bank.
   Assumes the host model and the bound checker. */
module test_rx_port_and_gpio_control_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  rx_hub_regs_pkg::reg_req_s req;
  rx_hub_regs_pkg::rx_status_s p0 = '0, p1 = '0;
  logic [7:0] rdata, d, v;
  logic link_ok_out, sync_out, en0, en1, vsel, p0_out, p0_oe, det = 1'b0;
  logic [1:0] smode;
  logic [6:0] pin_in = '0, in_en;
  logic [7:0] exp_q[$]; // Expected read bytes, oldest first
  logic rd_d = 1'b0; // Read strobe seen at the taking edge
  int error_cnt = 0, n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  i2c_host_model i_host (.sys_clk(sys_clk), .req(req));
  rx_port_and_gpio_control_regs i_dut (.sys_clk(sys_clk), .resetn(resetn), .req(req),
    .rdata(rdata), .port0_status(p0), .port1_status(p1), .link_ok_out(link_ok_out),
    .sync_out(sync_out), .first_receiver_enable(en0), .second_receiver_enable(en1),
    .detected_3v3(det), .pin_voltage_select(vsel), .supply_mode(smode), .pin_in(pin_in),
    .pin_input_enable(in_en), .pin0_out(p0_out), .pin0_oe(p0_oe));
  // Compare and count
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic final_report;
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [7:0] x, input logic rm);
    i_host.xfer(1'b1, a, x, rm);
  endtask : wr
  // Expectation noted before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    i_host.xfer(1'b0, a, 8'h00, 1'b0);
  endtask : rd
  // Outputs two edges behind a write are settled after this
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle
  // Read data lands one edge after the strobe; popped in its cycle
  always @(posedge sys_clk) begin
    rd_d <= req.rd;
    if (rd_d) cmp(rdata, exp_q.pop_front());
  end
  // Receiver status keeps moving so source picks are exercised
  always @(posedge sys_clk) begin
    #1;
    {p0, p1} <= 4'($urandom);
  end
  initial begin
    void'($urandom(92));
    repeat (10) @(posedge sys_clk);
    #1 resetn = 1'b1;
    rd(8'h0C, 8'h83);
    rd(8'h0D, 8'h09);
    rd(8'h0F, 8'h7F);
    rd(8'h10, 8'h00);
    rd(8'h3A, 8'h00);
    // Every link and sync code; remote write must leave both alone
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(8'h0C, {2'b00, i[1:0], ~i[1:0], d[1:0]}, 1'b0);
      rd(8'h0C, {2'b10, i[1:0], ~i[1:0], d[1:0]});
      wr(8'h0C, {2'b11, ~i[1:0], i[1:0], ~d[1:0]}, 1'b1);
      rd(8'h0C, {2'b10, i[1:0], ~i[1:0], ~d[1:0]});
    end
    d = 8'($urandom);
    det = d[0];
    settle();
    wr(8'h0D, {d[7], 1'b1, d[5:0]}, 1'b0);
    settle();
    cmp({5'h00, vsel, smode}, {5'h00, d[7], d[5:4]});
    rd(8'h0D, {d[7], 1'b1, d[5:0]});
    wr(8'h0D, d & 8'hBF, 1'b0);
    settle();
    cmp({5'h00, vsel, smode}, {5'h00, {3{det}}});
    rd(8'h0D, {det, 1'b0, {2{det}}, d[3:0]});
    d = 8'($urandom);
    pin_in = 7'($urandom);
    wr(8'h0F, d, 1'b0);
    rd(8'h0F, {1'b0, d[6:0]});
    rd(8'h0E, {1'b0, pin_in & d[6:0]});
    wr(8'h0E, 8'hFF, 1'b0);
    rd(8'h0E, {1'b0, pin_in & d[6:0]});
    wr(8'h0F, d & 8'h7E, 1'b0);
    // All eight sources, then register source with a nonzero select
    for (int j = 0; j < 9; j++) begin
      v = 8'($urandom);
      wr(8'h10, {((j == 8) ? 3'h1 : 3'h0), ((j == 8) ? 3'h4 : 3'(j)), v[0], 1'b1}, 1'b0);
      settle();
      cmp({6'h00, p0_oe, p0_out}, {6'h00, 1'b1, (j == 4 && v[0])});
    end
    settle();
    final_report();
  end
endmodule : test_rx_port_and_gpio_control_regs
